// ==== hw/irq_ctrl.sv ====
// Interrupt request flags and master enable behind an AXI4-Lite slave
// Operation
// [RULE_01] A source request sets its flag in the request register.
// [RULE_02] With master enable set, any pending flag raises the core request.
// [RULE_03] With master enable clear, no core request; flags stay readable.
// [RULE_04] Bit 7 is set by port pin 7 or the low-voltage detector.
// [RULE_05] Bit 6 is set by port pin 6 or the comparator.
// [RULE_06] Bits 5..0 follow the same-numbered port pin requests.
// [RULE_07] Enable, return-from-interrupt or software write of one sets master enable.
// [RULE_08] Disable, acknowledge, reset or software write of zero clears master enable.
// [RULE_09] Software writes zeros to the seven reserved control bits.
// [RULE_10] Flags hold until acknowledged or written zero; writing one raises a request.
module irq_ctrl (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic [15:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [15:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Request sources, one-cycle pulses on aclk
    input  wire logic [7:0]        port_pin_request,
    input  wire logic              low_voltage_detector,
    input  wire logic              comparator_request,
    // Processor core side
    input  wire logic              enable_interrupts_instruction,
    input  wire logic              disable_interrupts_instruction,
    input  wire logic              return_from_interrupt_instruction,
    input  wire logic              core_ack,
    input  wire logic [2:0]        core_ack_vector,
    output logic                   core_irq_request,
    output logic [2:0]             core_irq_vector
);
    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic        enable_reg;
    logic        enable_next;
    logic [15:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic [7:0]  src_vec;
    logic [7:0]  ack_vec;
    logic        do_write;
    logic        wr_req;
    logic        wr_ctl;
    logic        wr_map;
    logic [15:0] waddr_al;
    logic [15:0] raddr_al;
    logic [2:0]  vec_next;

    // -------------------------------------------------------------------------
    // Write channel: address and data taken in either order, then one response
    // -------------------------------------------------------------------------
    // Write strobes lane 0 only: registers are one byte wide
    assign waddr_al = {waddr_reg[15:2], 2'b00};
    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_req   = do_write && wstrb_reg[0] && (waddr_al == irq_pkg::REQ_ADDR);
    assign wr_ctl   = do_write && wstrb_reg[0] && (waddr_al == irq_pkg::CTL_ADDR);
    assign wr_map   = (waddr_al == irq_pkg::REQ_ADDR) || (waddr_al == irq_pkg::CTL_ADDR);

    // Address and data latches, released after the response is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= irq_pkg::RESP_OKAY;
            waddr_reg     <= '0;
            wdata_reg     <= '0;
            wstrb_reg     <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                waddr_reg     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
            end
            // Response code registered with bvalid so the output comes from a flop
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? irq_pkg::RESP_OKAY : irq_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Read channel: data one cycle after the address is taken
    // -------------------------------------------------------------------------
    assign raddr_al = {s_axi_araddr[15:2], 2'b00};

    // Reserved control bits and upper lanes read as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= irq_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= irq_pkg::RESP_OKAY;
            s_axi_rdata   <= '0;
            if (raddr_al == irq_pkg::REQ_ADDR) begin
                s_axi_rdata[7:0] <= flags_reg;                     // RULE_03
            end else if (raddr_al == irq_pkg::CTL_ADDR) begin
                s_axi_rdata[7:0] <= {enable_reg, irq_pkg::CTL_RESERVED};
            end else begin
                s_axi_rresp <= irq_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // -------------------------------------------------------------------------
    // Request flags
    // -------------------------------------------------------------------------
    // Pins 7 and 6 share their flag with the detector and comparator
    always_comb begin
        src_vec                             = port_pin_request;          // RULE_06
        src_vec[irq_pkg::LOWVOLT_BIT]       = port_pin_request[irq_pkg::LOWVOLT_BIT]
                                              || low_voltage_detector;   // RULE_04
        src_vec[irq_pkg::COMPARATOR_BIT]    = port_pin_request[irq_pkg::COMPARATOR_BIT]
                                              || comparator_request;     // RULE_05
        ack_vec                             = '0;
        if (core_ack) begin
            ack_vec[core_ack_vector] = 1'b1;
        end
    end

    // Source events win over acknowledge and software clear so none is lost
    always_comb begin
        flags_next = flags_reg & ~ack_vec;                               // RULE_10
        if (wr_req) begin
            flags_next = wdata_reg[7:0];                                 // RULE_10
        end
        flags_next = flags_next | src_vec;                               // RULE_01
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_reg <= irq_pkg::REQ_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // -------------------------------------------------------------------------
    // Master enable
    // -------------------------------------------------------------------------
    // Setting events take precedence over clearing events in the same cycle
    always_comb begin
        enable_next = enable_reg;
        if (disable_interrupts_instruction || core_ack) begin
            enable_next = 1'b0;                                          // RULE_08
        end
        if (wr_ctl) begin
            enable_next = wdata_reg[irq_pkg::ENABLE_BIT];                // RULE_07 RULE_08
        end
        if (enable_interrupts_instruction || return_from_interrupt_instruction) begin
            enable_next = 1'b1;                                          // RULE_07
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_reg <= irq_pkg::ENABLE_RESET;                         // RULE_08
        end else begin
            enable_reg <= enable_next;
        end
    end

    // -------------------------------------------------------------------------
    // Core request and vector
    // -------------------------------------------------------------------------
    // Highest-numbered pending flag is offered first
    always_comb begin
        vec_next = '0;
        for (int i = 0; i < irq_pkg::REQ_W; i++) begin
            if (flags_next[i]) begin
                vec_next = 3'(i);
            end
        end
    end

    // Built from next state so the request tracks the flops without a lag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_irq_request <= 1'b0;
            core_irq_vector  <= '0;
        end else begin
            core_irq_request <= enable_next && (flags_next != '0);       // RULE_02 RULE_03
            core_irq_vector  <= vec_next;
        end
    end

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    flag_set_a: assert property ((src_vec != '0) |=> ((flags_reg & $past(src_vec)) == $past(src_vec))) // RULE_01
        else $error("source request did not set its flag");
    req_forward_a: assert property ((enable_reg && flags_reg != '0) |-> core_irq_request) // RULE_02
        else $error("pending flag not forwarded while enabled");
    req_gated_a: assert property (core_irq_request |-> (enable_reg && flags_reg != '0)) // RULE_03
        else $error("request forwarded while disabled or idle");
    lowvolt_flag_a: assert property (low_voltage_detector |=> flags_reg[irq_pkg::LOWVOLT_BIT]) // RULE_04
        else $error("detector request missing on bit 7");
    comp_flag_a: assert property (comparator_request |=> flags_reg[irq_pkg::COMPARATOR_BIT]) // RULE_05
        else $error("comparator request missing on bit 6");
    pin_flag_a: assert property ((port_pin_request != '0)
        |=> ((flags_reg & $past(port_pin_request)) == $past(port_pin_request))) // RULE_06
        else $error("pin request missing on its flag");
    enable_set_a: assert property ((enable_interrupts_instruction || return_from_interrupt_instruction) |=> enable_reg) // RULE_07
        else $error("master enable not set");
    enable_clr_a: assert property ((disable_interrupts_instruction || core_ack) && !enable_interrupts_instruction
        && !return_from_interrupt_instruction && !wr_ctl |=> !enable_reg ##1 (enable_reg || !core_irq_request)) // RULE_08
        else $error("master enable not cleared");
    flag_hold_a: assert property (((~flags_reg & $past(flags_reg)) != '0) |-> $past(core_ack || wr_req)) // RULE_10
        else $error("flag dropped without acknowledge or write");
endmodule : irq_ctrl

// ==== inc/irq_pkg.sv ====
// Package: register map, field positions and bus codes of the interrupt request block
package irq_pkg;
    // -------------------------------------------------------------------------
    // Register indices and byte addresses
    // -------------------------------------------------------------------------
    localparam int          ADDR_W           = 16;
    localparam logic [11:0] REQ_INDEX        = 12'hfc3;
    localparam logic [11:0] CTL_INDEX        = 12'hfcf;
    localparam logic [15:0] REQ_ADDR         = {2'b00, REQ_INDEX, 2'b00};
    localparam logic [15:0] CTL_ADDR         = {2'b00, CTL_INDEX, 2'b00};
    // -------------------------------------------------------------------------
    // Fields and reset values
    // -------------------------------------------------------------------------
    localparam int          REQ_W            = 8;
    localparam int          LOWVOLT_BIT      = 7;
    localparam int          COMPARATOR_BIT   = 6;
    localparam int          ENABLE_BIT       = 7;
    localparam logic [7:0]  REQ_RESET        = 8'h00;
    localparam logic        ENABLE_RESET     = 1'b0;
    localparam logic [6:0]  CTL_RESERVED     = 7'h00;
    // -------------------------------------------------------------------------
    // Bus response codes
    // -------------------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage : irq_pkg

// ==== verification/irq_core_model.sv ====
// Behavioural processor core that acknowledges vectored interrupt requests
module irq_core_model (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Request from the controller
    input  wire logic       core_irq_request,
    input  wire logic [2:0] core_irq_vector,
    // Bench controls: acknowledge on, cycles to wait first
    input  wire logic       ack_on,
    input  wire logic [3:0] ack_delay,
    // Acknowledge back to the controller
    output logic            core_ack,
    output logic [2:0]      core_ack_vector
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_reg;
    // Wait, then one acknowledge pulse; vector is deliberately wrong outside the pulse
    always_ff @(posedge aclk) begin
        if (!aresetn || !core_irq_request || !ack_on || core_ack) begin
            wait_reg        <= 4'h0;
            core_ack        <= 1'b0;
            core_ack_vector <= ~core_irq_vector;
        end else if (wait_reg == ack_delay) begin
            core_ack        <= 1'b1;
            core_ack_vector <= core_irq_vector;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule : irq_core_model

// ==== verification/irq_ctrl_test.sv ====
// Self-checking bench for the request flags and master enable block
module irq_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic        aclk = 1'b0, aresetn = 1'b0, ack_on = 1'b0;
    logic [15:0] awaddr = 16'h0, araddr = 16'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0, lanes = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq_req, ack;
    logic [1:0]  bresp, rresp;
    logic [2:0]  irq_vec, ack_vec;
    logic [7:0]  pins = 8'h0;
    logic        lowv = 1'b0, cmp = 1'b0, op_en = 1'b0, op_dis = 1'b0, op_ret = 1'b0;
    int          failures = 0, samples_checked = 0, cycles = 0;
    irq_ctrl u_irq_ctrl (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .port_pin_request(pins), .low_voltage_detector(lowv), .comparator_request(cmp),
        .enable_interrupts_instruction(op_en), .disable_interrupts_instruction(op_dis),
        .return_from_interrupt_instruction(op_ret), .core_ack(ack), .core_ack_vector(ack_vec),
        .core_irq_request(irq_req), .core_irq_vector(irq_vec));
    irq_core_model u_irq_core_model (
        .aclk(aclk), .aresetn(aresetn), .core_irq_request(irq_req), .core_irq_vector(irq_vec),
        .ack_on(ack_on), .ack_delay(4'h2), .core_ack(ack), .core_ack_vector(ack_vec));
    // Clock and hang guard; the whole run needs well under a thousand cycles
    always #25 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            complete_run();
        end
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // Address and data offered together, each dropped once taken
    task automatic axi_write(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, 24'h0, d, lanes};
        {awvalid, wvalid, bready} <= 3'b111;
        while (!done) begin
            @(posedge aclk);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
            if (bvalid && bready) begin
                check("bresp", {30'h0, er}, {30'h0, bresp});
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : axi_write
    task automatic expect_reg(input string name, input logic [15:0] a, input logic [7:0] exp,
                              input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        while (!done) begin
            @(posedge aclk);
            if (arready && arvalid) arvalid <= 1'b0;
            if (rvalid && rready) begin
                check(name, {24'h0, exp}, rdata);
                check("rresp", {30'h0, er}, {30'h0, rresp});
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : expect_reg
    // One-cycle pulse of {return, disable, enable, comparator, low voltage, pins}
    task automatic pulse(input logic [12:0] v);
        @(posedge aclk);
        {op_ret, op_dis, op_en, cmp, lowv, pins} <= v;
        @(posedge aclk);
        {op_ret, op_dis, op_en, cmp, lowv, pins} <= 13'h0;
        @(negedge aclk);
    endtask : pulse
    // ----------------------------------------------------------------
    // Tables and sequence
    // ----------------------------------------------------------------
    typedef struct packed {logic [12:0] src; logic [7:0] flags; logic [2:0] vec;} irq_row_s;
    irq_row_s rows [8] = '{'{13'h0001, 8'h01, 3'h0}, '{13'h0024, 8'h24, 3'h5},
        '{13'h0080, 8'h80, 3'h7}, '{13'h0100, 8'h80, 3'h7}, '{13'h0200, 8'h40, 3'h6},
        '{13'h0040, 8'h40, 3'h6}, '{13'h0300, 8'hc0, 3'h7}, '{13'h003f, 8'h3f, 3'h5}};
    typedef struct packed {logic [12:0] src; logic [7:0] wval; logic [7:0] exp;} irq_ctl_s;
    irq_ctl_s ctl_rows [7] = '{'{13'h0400, 8'h00, 8'h80}, '{13'h0800, 8'h00, 8'h00},
        '{13'h1000, 8'h00, 8'h80}, '{13'h0000, 8'h00, 8'h00}, '{13'h0000, 8'h80, 8'h80},
        '{13'h0800, 8'h00, 8'h00}, '{13'h0000, 8'h80, 8'h80}};
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        expect_reg("flags", irq_pkg::REQ_ADDR, 8'h00, irq_pkg::RESP_OKAY);
        expect_reg("control", irq_pkg::CTL_ADDR, 8'h00, irq_pkg::RESP_OKAY);
        expect_reg("unmapped", 16'h0100, 8'h00, irq_pkg::RESP_SLVERR);
        axi_write(16'h0104, 8'hff, irq_pkg::RESP_SLVERR);
        // Sources with master enable clear: flags set and readable, nothing forwarded
        foreach (rows[i]) begin
            axi_write(irq_pkg::REQ_ADDR, 8'h00, irq_pkg::RESP_OKAY);
            pulse(rows[i].src);
            check("request", 32'h0, {31'h0, irq_req});
            check("vector", {29'h0, rows[i].vec}, {29'h0, irq_vec});
            expect_reg("flags", irq_pkg::REQ_ADDR, rows[i].flags, 2'h0);
        end
        // Enable set and cleared by instructions and by writes; reserved bits read zero
        foreach (ctl_rows[i]) begin
            if (ctl_rows[i].src != 13'h0) pulse(ctl_rows[i].src);
            else axi_write(irq_pkg::CTL_ADDR, ctl_rows[i].wval, irq_pkg::RESP_OKAY);
            expect_reg("control", irq_pkg::CTL_ADDR, ctl_rows[i].exp, 2'h0);
        end
        // Two flags raised by software, core acknowledges only the higher one
        ack_on <= 1'b1;
        axi_write(irq_pkg::REQ_ADDR, 8'h88, irq_pkg::RESP_OKAY);
        pulse(13'h0400);
        check("request", 32'h1, {31'h0, irq_req});
        check("vector", 32'h7, {29'h0, irq_vec});
        while (irq_req !== 1'b0) @(posedge aclk);
        expect_reg("flags", irq_pkg::REQ_ADDR, 8'h08, irq_pkg::RESP_OKAY);
        expect_reg("control", irq_pkg::CTL_ADDR, 8'h00, irq_pkg::RESP_OKAY);
        // Reset in mid-run with a request standing
        ack_on <= 1'b0;
        pulse(13'h0400);
        check("request", 32'h1, {31'h0, irq_req});
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        check("request", 32'h0, {31'h0, irq_req});
        expect_reg("flags", irq_pkg::REQ_ADDR, 8'h00, irq_pkg::RESP_OKAY);
        expect_reg("control", irq_pkg::CTL_ADDR, 8'h00, irq_pkg::RESP_OKAY);
        // Lane 0 strobe clear: write dropped, still answered by its address
        lanes = 4'he;
        axi_write(irq_pkg::REQ_ADDR, 8'hff, irq_pkg::RESP_OKAY);
        expect_reg("flags", irq_pkg::REQ_ADDR, 8'h00, irq_pkg::RESP_OKAY);
        complete_run();
    end
endmodule : irq_ctrl_test
